// ==== irq_port_monitor.sv ====
// Purpose: Port checks for the USB hub interrupt unit
// Assumes: One clock, rst synchronous and active high
// Notes: Flags sit inside; judged through reads and resets
`timescale 1ns/1ns
module irq_port_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] address,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   input wire logic bus_reset,
   input wire logic usb_reset,
   input wire logic cpu_reset,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence fl; read_strobe && address == 16'h1ff7; endsequence
   sequence en; read_strobe && address == 16'h1ff3; endsequence
   sequence ak; read_strobe && address == 16'h1ff5; endsequence
   sequence sf; read_strobe && address == 16'h1ffa; endsequence
   sequence se; read_strobe && address == 16'h1ffb; endsequence
   sequence br; bus_reset && !cpu_reset; endsequence
   AST_F: assert property (fl |=> !read_data[5:4]) else $error("rsvd");
   AST_E: assert property (en |=> !read_data[5:4]) else $error("rsvd");
   AST_A: assert property (ak |=> !read_data) else $error("ack");
   AST_SF: assert property (sf |=> !read_data[7:4]) else $error("rsvd");
   AST_SE: assert property (se |=> !read_data[7:4]) else $error("rsvd");
   AST_UR: assert property (usb_reset == bus_reset) else $error("usb");
   AST_CR: assert property (cpu_reset |-> bus_reset) else $error("cpu");
   AST_BI: assert property (br |=> irq) else $error("bus irq");
endmodule : irq_port_monitor
bind usb_hub_interrupt_unit irq_port_monitor irq_port_monitor_inst (.*);

// ==== usb_event_model.sv ====
// Purpose: Stand-in for the frame timer and USB event hardware
// Assumes: One kick bit per event, acted on at the next edge
// Notes: Bus reset comes pre-qualified, so one cycle stands for it
`timescale 1ns/1ns
module usb_event_model (
   input wire logic clock,
   input wire logic [7:0] kick,
   input wire logic [7:0] ep_kick,
   output logic [3:0] ep_rx_out_set,
   output logic [3:0] ep_rx_setup_set,
   output logic sof_received,
   output logic eof2_point,
   output logic wakeup_request,
   output logic global_suspend,
   output logic [3:0] port_resume,
   output logic [3:0] ep_tx_complete_set,
   output logic bus_reset
);
   always_ff @(posedge clock) begin
      sof_received <= kick[0];
      eof2_point <= kick[1];
      wakeup_request <= kick[2];
      global_suspend <= kick[3];
      port_resume <= {1'h0, kick[5], 1'h0, kick[4]};
      ep_tx_complete_set <= {2'h0, kick[6], 1'h0};
      bus_reset <= kick[7];
      ep_rx_out_set <= ep_kick[3:0];
      ep_rx_setup_set <= ep_kick[7:4];
   end
endmodule : usb_event_model

// ==== usb_hub_interrupt_unit.sv ====
// Purpose: Collect USB hub and function events into CPU interrupt flags
// Assumes: Event inputs are one-cycle pulses synchronous to clock
// Notes: EOF2 timing comes from the hub frame timer as a pulse
`timescale 1ns/1ns
module usb_hub_interrupt_unit (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic sof_received,
   input wire logic eof2_point,
   input wire logic [3:0] ep_rx_out_set,
   input wire logic [3:0] ep_tx_ready_cleared,
   input wire logic [3:0] ep_tx_complete_set,
   input wire logic [3:0] ep_stall_sent_set,
   input wire logic [3:0] ep_rx_setup_set,
   input wire logic [7:0] ep_type,
   input wire logic wakeup_request,
   input wire logic [3:0] port_resume,
   input wire logic global_suspend,
   input wire logic bus_reset,
   output logic usb_reset,
   output logic cpu_reset,
   output logic irq
);
   // Endpoint index order: 0 func ep0, 1 func ep1, 2 func ep2, 3 hub ep0
   logic [7:0] event_flags;
   logic [7:0] next_event_flags;
   logic [7:0] event_enable;
   logic [7:0] next_event_enable;
   logic [7:0] sr_flags;
   logic [7:0] next_sr_flags;
   logic [7:0] sr_enable;
   logic [7:0] next_sr_enable;
   logic [7:0] read_value;
   logic [7:0] next_read_data;
   logic [1:0] ep_kind [usb_irq_pkg::EP_COUNT];
   logic [3:0] rx_out_hit;
   logic [3:0] tx_ready_hit;
   logic [3:0] tx_done_hit;
   logic [3:0] stall_hit;
   logic [3:0] setup_hit;
   logic [3:0] ep_hit;
   logic [7:0] event_set;
   logic [7:0] sr_set;
   logic [7:0] event_clear;
   logic [7:0] sr_keep;
   logic [7:0] event_pending;
   logic [7:0] sr_pending;
   logic event_request;
   logic sr_request;
   logic write_event_enable;
   logic write_event_ack;
   logic write_sr_flags;
   logic write_sr_enable;
   logic read_event_flags;
   logic read_event_enable;
   logic read_event_ack;
   logic read_sr_flags;
   logic read_sr_enable;
   logic any_read;
   logic resume_seen;
   logic split_reset;
   logic bus_reset_flag_set;
   logic frame_start_flag;
   logic frame_end_two_flag;
   logic hub_ep_zero_flag;
   logic func_ep_zero_flag;
   logic func_ep_one_flag;
   logic func_ep_two_flag;
   logic remote_wakeup_flag;
   logic resume_flag;
   logic global_suspend_flag;
   logic bus_reset_flag;
   logic frame_start_irq_on;
   logic frame_end_two_irq_on;
   logic hub_ep_zero_irq_on;
   logic func_ep_zero_irq_on;
   logic func_ep_one_irq_on;
   logic func_ep_two_irq_on;
   logic remote_wakeup_irq_on;
   logic resume_irq_on;
   logic global_suspend_irq_on;
   logic bus_reset_irq_on;

   // Decode shared by every register select
   function automatic logic selects(input logic [15:0] addr,
         input logic [15:0] target, input logic strobe);
      selects = strobe & (addr == target);
   endfunction : selects

   // Mask and merge shared by both flag groups
   function automatic logic [7:0] merge_flags(input logic [7:0] held,
         input logic [7:0] set, input logic [7:0] mask);
      merge_flags = (held | set) & mask;
   endfunction : merge_flags

   // Endpoint kind decode, used by every trigger term
   function automatic logic is_control(input logic [1:0] kind);
      is_control = (kind == usb_irq_pkg::EP_CONTROL);
   endfunction : is_control

   function automatic logic is_out(input logic [1:0] kind);
      is_out = (kind == usb_irq_pkg::EP_OUT);
   endfunction : is_out

   function automatic logic is_in(input logic [1:0] kind);
      is_in = (kind == usb_irq_pkg::EP_IN);
   endfunction : is_in

   // One gate per source keeps the request terms uniform
   function automatic logic request(input logic flag, input logic enabled);
      request = flag & enabled;
   endfunction : request

   // Tx done alone also counts, so the ready-cleared term adds nothing new
   function automatic logic ep_trigger(input logic [1:0] kind,
         input logic rx_out, input logic tx_rdy_clr, input logic tx_done,
         input logic stall, input logic setup);
      logic ctl;
      logic outp;
      logic inp;
      ctl = is_control(kind);
      outp = is_out(kind);
      inp = is_in(kind);
      ep_trigger = ((ctl | outp) & rx_out)
         | ((ctl | inp) & tx_rdy_clr & tx_done)
         | ((ctl | inp) & (tx_done | stall))
         | (ctl & setup);
   endfunction : ep_trigger

   always_comb begin
      for (int i = 0; i < usb_irq_pkg::EP_COUNT; i++) begin
         ep_kind[i] = ep_type[2*i +: 2];
      end
   end

   // Per-endpoint terms kept apart so each trigger can be traced
   always_comb begin
      rx_out_hit = 4'h0;
      tx_ready_hit = 4'h0;
      tx_done_hit = 4'h0;
      stall_hit = 4'h0;
      setup_hit = 4'h0;
      for (int i = 0; i < usb_irq_pkg::EP_COUNT; i++) begin
         rx_out_hit[i] = ep_rx_out_set[i];
         tx_ready_hit[i] = ep_tx_ready_cleared[i];
         tx_done_hit[i] = ep_tx_complete_set[i];
         stall_hit[i] = ep_stall_sent_set[i];
         setup_hit[i] = ep_rx_setup_set[i];
      end
   end

   always_comb begin
      ep_hit = 4'h0;
      for (int i = 0; i < usb_irq_pkg::EP_COUNT; i++) begin
         ep_hit[i] = ep_trigger(ep_kind[i], rx_out_hit[i],
            tx_ready_hit[i], tx_done_hit[i], stall_hit[i],
            setup_hit[i]);
      end
   end

   // Address compare only; the master never raises both strobes
   always_comb begin
      write_event_enable = selects(address,
         usb_irq_pkg::ADDR_EVENT_ENABLE, write_strobe);
      write_event_ack = selects(address,
         usb_irq_pkg::ADDR_EVENT_ACK, write_strobe);
      write_sr_flags = selects(address,
         usb_irq_pkg::ADDR_SR_FLAGS, write_strobe);
      write_sr_enable = selects(address,
         usb_irq_pkg::ADDR_SR_ENABLE, write_strobe);
      read_event_flags = selects(address,
         usb_irq_pkg::ADDR_EVENT_FLAGS, read_strobe);
      read_event_enable = selects(address,
         usb_irq_pkg::ADDR_EVENT_ENABLE, read_strobe);
      read_event_ack = selects(address,
         usb_irq_pkg::ADDR_EVENT_ACK, read_strobe);
      read_sr_flags = selects(address,
         usb_irq_pkg::ADDR_SR_FLAGS, read_strobe);
      read_sr_enable = selects(address,
         usb_irq_pkg::ADDR_SR_ENABLE, read_strobe);
      any_read = read_strobe;
   end

   // Frame flags come straight from single-cycle timer pulses
   always_comb begin
      event_set = 8'h00;
      event_set[usb_irq_pkg::BIT_SOF] = sof_received;
      event_set[usb_irq_pkg::BIT_EOF2] = eof2_point;
      event_set[usb_irq_pkg::BIT_FUNC_EP0] = ep_hit[0];
      event_set[usb_irq_pkg::BIT_FUNC_EP1] = ep_hit[1];
      event_set[usb_irq_pkg::BIT_FUNC_EP2] = ep_hit[2];
      event_set[usb_irq_pkg::BIT_HUB_EP0] = ep_hit[3];
   end

   // Port one is the upstream port, so its resume never flags
   always_comb begin
      resume_seen = |port_resume[3:1];
      split_reset = sr_enable[usb_irq_pkg::BIT_BUS_RESET];
      bus_reset_flag_set = bus_reset & split_reset;
      sr_set = 8'h00;
      sr_set[usb_irq_pkg::BIT_WAKEUP] = wakeup_request;
      sr_set[usb_irq_pkg::BIT_RESUME] = resume_seen;
      sr_set[usb_irq_pkg::BIT_SUSPEND] = global_suspend;
      sr_set[usb_irq_pkg::BIT_BUS_RESET] = bus_reset_flag_set;
   end

   // Set wins over a clear arriving in the same cycle
   always_comb begin
      event_clear = 8'h00;
      if (write_event_ack) begin
         event_clear = write_data;
      end
      next_event_flags = merge_flags(event_flags & ~event_clear,
         event_set, usb_irq_pkg::EVENT_MASK);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         event_flags <= usb_irq_pkg::RESET_VALUE;
      end else begin
         event_flags <= next_event_flags;
      end
   end

   // Reserved enable bits are not stored, so they always read zero
   always_comb begin
      next_event_enable = event_enable;
      if (write_event_enable) begin
         next_event_enable = write_data & usb_irq_pkg::EVENT_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         event_enable <= usb_irq_pkg::RESET_VALUE;
      end else begin
         event_enable <= next_event_enable;
      end
   end

   // Writing zero clears; writing one leaves a flag as it is
   always_comb begin
      sr_keep = 8'hff;
      if (write_sr_flags) begin
         sr_keep = write_data;
      end
      next_sr_flags = merge_flags(sr_flags & sr_keep, sr_set,
         usb_irq_pkg::SR_MASK);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sr_flags <= usb_irq_pkg::RESET_VALUE;
      end else begin
         sr_flags <= next_sr_flags;
      end
   end

   // Bit 3 here splits the USB reset from the controller reset
   always_comb begin
      next_sr_enable = sr_enable;
      if (write_sr_enable) begin
         next_sr_enable = write_data & usb_irq_pkg::SR_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sr_enable <= usb_irq_pkg::RESET_VALUE;
      end else begin
         sr_enable <= next_sr_enable;
      end
   end

   // Acknowledge and unmapped addresses fall through to zero
   always_comb begin
      read_value = 8'h00;
      if (read_event_flags) begin
         read_value = event_flags;
      end
      if (read_event_enable) begin
         read_value = event_enable;
      end
      if (read_event_ack) begin
         read_value = 8'h00;
      end
      if (read_sr_flags) begin
         read_value = sr_flags;
      end
      if (read_sr_enable) begin
         read_value = sr_enable;
      end
      next_read_data = 8'h00;
      if (any_read) begin
         next_read_data = read_value;
      end
   end

   // Read data stands one cycle only and is zero otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         read_data <= 8'h00;
      end else begin
         read_data <= next_read_data;
      end
   end

   // Named views of the stored bits, one per interrupt source
   always_comb begin
      frame_start_flag = event_flags[usb_irq_pkg::BIT_SOF];
      frame_end_two_flag = event_flags[usb_irq_pkg::BIT_EOF2];
      hub_ep_zero_flag = event_flags[usb_irq_pkg::BIT_HUB_EP0];
      func_ep_zero_flag = event_flags[usb_irq_pkg::BIT_FUNC_EP0];
      func_ep_one_flag = event_flags[usb_irq_pkg::BIT_FUNC_EP1];
      func_ep_two_flag = event_flags[usb_irq_pkg::BIT_FUNC_EP2];
      remote_wakeup_flag = sr_flags[usb_irq_pkg::BIT_WAKEUP];
      resume_flag = sr_flags[usb_irq_pkg::BIT_RESUME];
      global_suspend_flag = sr_flags[usb_irq_pkg::BIT_SUSPEND];
      bus_reset_flag = sr_flags[usb_irq_pkg::BIT_BUS_RESET];
      frame_start_irq_on = event_enable[usb_irq_pkg::BIT_SOF];
      frame_end_two_irq_on = event_enable[usb_irq_pkg::BIT_EOF2];
      hub_ep_zero_irq_on = event_enable[usb_irq_pkg::BIT_HUB_EP0];
      func_ep_zero_irq_on = event_enable[usb_irq_pkg::BIT_FUNC_EP0];
      func_ep_one_irq_on = event_enable[usb_irq_pkg::BIT_FUNC_EP1];
      func_ep_two_irq_on = event_enable[usb_irq_pkg::BIT_FUNC_EP2];
      remote_wakeup_irq_on = sr_enable[usb_irq_pkg::BIT_WAKEUP];
      resume_irq_on = sr_enable[usb_irq_pkg::BIT_RESUME];
      global_suspend_irq_on = sr_enable[usb_irq_pkg::BIT_SUSPEND];
      bus_reset_irq_on = sr_enable[usb_irq_pkg::BIT_BUS_RESET];
   end

   // Combinational so an enable change shows at once
   always_comb begin
      event_pending = 8'h00;
      event_pending[usb_irq_pkg::BIT_SOF] = request(frame_start_flag,
         frame_start_irq_on);
      event_pending[usb_irq_pkg::BIT_EOF2] = request(frame_end_two_flag,
         frame_end_two_irq_on);
      event_pending[usb_irq_pkg::BIT_HUB_EP0] = request(hub_ep_zero_flag,
         hub_ep_zero_irq_on);
      event_pending[usb_irq_pkg::BIT_FUNC_EP0] = request(func_ep_zero_flag,
         func_ep_zero_irq_on);
      event_pending[usb_irq_pkg::BIT_FUNC_EP1] = request(func_ep_one_flag,
         func_ep_one_irq_on);
      event_pending[usb_irq_pkg::BIT_FUNC_EP2] = request(func_ep_two_flag,
         func_ep_two_irq_on);
      sr_pending = 8'h00;
      sr_pending[usb_irq_pkg::BIT_WAKEUP] = request(remote_wakeup_flag,
         remote_wakeup_irq_on);
      sr_pending[usb_irq_pkg::BIT_RESUME] = request(resume_flag,
         resume_irq_on);
      sr_pending[usb_irq_pkg::BIT_SUSPEND] = request(global_suspend_flag,
         global_suspend_irq_on);
      sr_pending[usb_irq_pkg::BIT_BUS_RESET] = request(bus_reset_flag,
         bus_reset_irq_on);
      event_request = |event_pending;
      sr_request = |sr_pending;
      irq = event_request | sr_request;
   end

   // Bus reset always reaches the USB side; the CPU only when not split
   always_comb begin
      usb_reset = bus_reset;
      cpu_reset = bus_reset & ~split_reset;
   end
endmodule : usb_hub_interrupt_unit

// ==== usb_hub_interrupt_unit_tb.sv ====
// Purpose: Self-checking bench for the USB hub interrupt unit
// Assumes: Function endpoint 1 is IN, the others control
// Notes: Tx-ready-cleared and stall pulses held low to keep it short
`timescale 1ns/1ns
module usb_hub_interrupt_unit_tb;
   logic clock = 1'h0, rst = 1'h1, write_strobe = 1'h0, read_strobe = 1'h0;
   logic sof_received, eof2_point, wakeup_request, global_suspend, bus_reset;
   logic usb_reset, cpu_reset, irq;
   logic [15:0] address = 16'h0000;
   logic [7:0] write_data = 8'h00, read_data, kick = 8'h00;
   logic [3:0] port_resume, ep_tx_complete_set;
   logic [3:0] ep_rx_out_set, ep_rx_setup_set;
   logic [7:0] ep_kick = 8'h00;
   int err_count = 0, checks_done = 0;
   usb_event_model usb_event_model_inst (.*);
   usb_hub_interrupt_unit usb_hub_interrupt_unit_inst (.*, .ep_type(8'h08),
      .ep_tx_ready_cleared(4'h0), .ep_stall_sent_set(4'h0));
   initial forever #20 clock = ~clock;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : cmp
   // Every access also checks irq, so masking slips show at once
   task automatic acc(input logic w, input logic [15:0] a,
         input logic [7:0] d, input logic i);
      address <= a;
      write_data <= d;
      write_strobe <= w;
      read_strobe <= !w;
      @(posedge clock);
      write_strobe <= 1'h0;
      read_strobe <= 1'h0;
      #1 cmp({7'h0, irq}, {7'h0, i});
      if (!w) cmp(read_data, d);
      @(posedge clock);
   endtask : acc
   task automatic fire(input logic [7:0] k, input logic [1:0] r);
      kick <= k;
      @(posedge clock);
      kick <= 8'h00;
      #1 cmp({6'h0, usb_reset, cpu_reset}, {6'h0, r});
      @(posedge clock);
   endtask : fire
   task automatic frame_events;
      acc(1'h1, 16'h1ff3, 8'hff, 1'h0);
      acc(1'h0, 16'h1ff3, 8'hcf, 1'h0);
      fire(8'h43, 2'h0);
      acc(1'h0, 16'h1ff7, 8'hc2, 1'h1);
      acc(1'h1, 16'h1ff5, 8'h40, 1'h1);
      acc(1'h0, 16'h1ff7, 8'h82, 1'h1);
      acc(1'h1, 16'h1ff3, 8'h4d, 1'h0);
      acc(1'h0, 16'h1ff5, 8'h00, 1'h0);
      acc(1'h1, 16'h1ff5, 8'hff, 1'h0);
      acc(1'h0, 16'h1ff7, 8'h00, 1'h0);
      acc(1'h0, 16'h1ff4, 8'h00, 1'h0);
   endtask : frame_events
   task automatic ep_fire(input logic [7:0] e);
      ep_kick <= e;
      @(posedge clock);
      ep_kick <= 8'h00;
      @(posedge clock);
   endtask : ep_fire
   // Rx and setup on the IN endpoint must leave no trace
   task automatic ep_events;
      ep_fire(8'h22);
      acc(1'h0, 16'h1ff7, 8'h00, 1'h0);
      ep_fire(8'h81);
      acc(1'h0, 16'h1ff7, 8'h09, 1'h1);
      acc(1'h1, 16'h1ff5, 8'h09, 1'h0);
      acc(1'h0, 16'h1ff7, 8'h00, 1'h0);
   endtask : ep_events
   // Port 1 resume rides with wakeup and must leave no trace
   task automatic sr_events;
      acc(1'h1, 16'h1ffb, 8'hf7, 1'h0);
      acc(1'h0, 16'h1ffb, 8'h07, 1'h0);
      fire(8'h14, 2'h0);
      acc(1'h0, 16'h1ffa, 8'h04, 1'h1);
      fire(8'h28, 2'h0);
      acc(1'h0, 16'h1ffa, 8'h07, 1'h1);
      acc(1'h1, 16'h1ffa, 8'h03, 1'h1);
      acc(1'h1, 16'h1ffb, 8'h08, 1'h0);
      fire(8'h80, 2'h2);
      acc(1'h0, 16'h1ffa, 8'h0b, 1'h1);
      acc(1'h1, 16'h1ffa, 8'h00, 1'h0);
      acc(1'h1, 16'h1ffb, 8'h00, 1'h0);
      fire(8'h80, 2'h3);
      acc(1'h0, 16'h1ffa, 8'h00, 1'h0);
   endtask : sr_events
   task automatic complete_run;
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'h0;
      frame_events();
      ep_events();
      sr_events();
      complete_run();
   end
   initial begin
      repeat (400) @(posedge clock);
      err_count++;
      complete_run();
   end
endmodule : usb_hub_interrupt_unit_tb

// ==== usb_irq_pkg.sv ====
// Purpose: Constants for the USB hub/function interrupt unit
// Assumes: Byte-wide register port, 25 MHz device clock
// Notes: Offsets are the printed word addresses of the register space
//
// Overview of operation
// - Endpoint flag sets when hardware updates that endpoint's control/status
// - Endpoint triggers depend on type: control, OUT or IN
// - Start-of-frame flag, bit 7, sets on a valid frame start packet
// - Frame-end-two flag, bit 6, sets ten clocks before next frame
// - Bits 5 and 4 of flags, acknowledge and enable read zero
// - Writing one to acknowledge bit clears the matching flag
// - Each frame/endpoint source requests only while its enable is one
// - Remote wakeup flag, bit 2, sets on wakeup request
// - Resume flag, bit 1, sets on resume at ports other than one
// - Global suspend flag, bit 0, sets on global suspend signaling
// - Suspend/resume flag with its enable set raises interrupt
// - With bus-reset enable, bus reset resets USB only, sets bit 3
// - Upper reserved suspend/resume bits read as zero
// - Writing zero to a suspend/resume flag bit clears that flag
package usb_irq_pkg;
   localparam logic [15:0] ADDR_EVENT_ENABLE = 16'h1ff3;
   localparam logic [15:0] ADDR_EVENT_ACK = 16'h1ff5;
   localparam logic [15:0] ADDR_EVENT_FLAGS = 16'h1ff7;
   localparam logic [15:0] ADDR_SR_FLAGS = 16'h1ffa;
   localparam logic [15:0] ADDR_SR_ENABLE = 16'h1ffb;
   localparam logic [7:0] EVENT_MASK = 8'hcf;
   localparam logic [7:0] SR_MASK = 8'h0f;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int BIT_SOF = 7;
   localparam int BIT_EOF2 = 6;
   localparam int BIT_HUB_EP0 = 3;
   localparam int BIT_FUNC_EP2 = 2;
   localparam int BIT_FUNC_EP1 = 1;
   localparam int BIT_FUNC_EP0 = 0;
   localparam int BIT_BUS_RESET = 3;
   localparam int BIT_WAKEUP = 2;
   localparam int BIT_RESUME = 1;
   localparam int BIT_SUSPEND = 0;
   localparam int EP_COUNT = 4;
   localparam logic [1:0] EP_CONTROL = 2'h0;
   localparam logic [1:0] EP_OUT = 2'h1;
   localparam logic [1:0] EP_IN = 2'h2;
endpackage : usb_irq_pkg
